// File: logic/gps_clear_cell.v
`timescale 1ns/100ps
`include "gps_defines.vh"

// One port-8 bit: picks which resets clear the data bit and its pin config
module gps_clear_cell
(
   input  wire core_clk,
   input  wire resetn,
   input  wire sel,
   input  wire standby_por,
   input  wire main_por,
   input  wire pci_reset,
   output reg  clear_reg
);

   wire clear_next;

   // Standby reset always clears; the wider set only when selected
   assign clear_next = standby_por | (sel & (main_por | pci_reset));

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clear_reg <= 1'b1;
      end
      else
      begin
         clear_reg <= clear_next;
      end
   end

endmodule

// File: logic/gps_defines.vh
`ifndef GPS_DEFINES_VH
`define GPS_DEFINES_VH

// Register indices; byte address is four times the index
`define GPS_IDX_RST_SEL        8'hF6
`define GPS_IDX_SUPPLY_CTRL    8'hF8
`define GPS_IDX_SUPPLY_STATUS  8'hFA

`define GPS_ADDR_W             12

// Reset values
`define GPS_RST_SEL_RESET      8'h00
`define GPS_SUPPLY_CTRL_RESET  8'h00

// Supply control field positions
`define GPS_SC_ALARM_WAKE      0
`define GPS_SC_KEEP_OFF        1
`define GPS_SC_POWER_ON        2
`define GPS_SC_MASK            8'h07

// Supply status field positions
`define GPS_ST_STANDBY         0
`define GPS_ST_PIN_LEVEL       1
`define GPS_ST_SUPPLY_ON       2
`define GPS_ST_WAKE_PENDING    3
`define GPS_ST_LAST_ON         4

`endif

// File: logic/gps_power_ctrl.v
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "gps_defines.vh"

// Notes on behaviour
// - select bit 0 standby only, 1 adds PCI/main
// - select bit n governs data n, config n
// - eight independent per-pin reset selections
// - alarm during standby loss powers up on return
// - button override flag blocks alarm power-up
// - keep-off releases supply pin on standby reset
// - neither bit set restores pre-loss supply state
module gps_power_ctrl
#(
   parameter NBITS = 8
)
(
   input  wire                     core_clk,
   input  wire                     resetn,
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [`GPS_ADDR_W-1:0]   paddr,
   input  wire [31:0]              pwdata,
   output reg  [31:0]              prdata,
   output wire                     pready,
   output reg                      pslverr,
   input  wire                     standby_por,
   input  wire                     main_por,
   input  wire                     pci_reset,
   input  wire                     standby_present,
   input  wire                     alarm_fire,
   input  wire                     alarm_enable,
   input  wire                     button_override_flag,
   input  wire                     main_on_request,
   output wire [NBITS-1:0]         port8_data_clear,
   output wire [NBITS-1:0]         port8_config_clear,
   input  wire                     power_supply_on_n_in,
   output wire                     power_supply_on_n_out,
   output wire                     power_supply_on_n_oe
);

   localparam ST_RUN  = 2'b00;
   localparam ST_LOST = 2'b01;
   localparam ST_OFF  = 2'b10;

   reg  [7:0]  port8_reset_select_reg;
   reg  [7:0]  supply_control_reg;
   reg         supply_on_reg;
   reg         last_on_reg;
   reg         wake_pending_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg         supply_on_next;
   reg  [31:0] rdata_next;
   reg         err_next;

   wire [NBITS-1:0] clear_bits;
   wire             setup_phase;
   wire             wr_access;
   wire             alarm_wake_on_loss_en;
   wire             standby_loss_keep_off;
   wire             standby_loss_power_on;
   wire             wake_event;

   function [1:0] reg_decode;
      input [`GPS_ADDR_W-1:0] addr;
      begin
         if (addr == {2'b00, `GPS_IDX_RST_SEL, 2'b00})
            reg_decode = 2'd1;
         else if (addr == {2'b00, `GPS_IDX_SUPPLY_CTRL, 2'b00})
            reg_decode = 2'd2;
         else if (addr == {2'b00, `GPS_IDX_SUPPLY_STATUS, 2'b00})
            reg_decode = 2'd3;
         else
            reg_decode = 2'd0;
      end
   endfunction

   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pwrite;
   // Zero wait states; read data captured in setup, stable in access
   assign pready      = 1'b1;

   assign alarm_wake_on_loss_en = supply_control_reg[`GPS_SC_ALARM_WAKE];
   assign standby_loss_keep_off = supply_control_reg[`GPS_SC_KEEP_OFF];
   assign standby_loss_power_on = supply_control_reg[`GPS_SC_POWER_ON];

   // Alarm hit while the standby rail is gone
   assign wake_event = alarm_fire & alarm_enable & alarm_wake_on_loss_en
                       & ~standby_present & ~button_override_flag;

   genvar gi;
   generate
      for (gi = 0; gi < NBITS; gi = gi + 1)
      begin : g_cell
         gps_clear_cell u_cell
         (
            .core_clk    (core_clk),
            .resetn      (resetn),
            .sel         (port8_reset_select_reg[gi]),
            .standby_por (standby_por),
            .main_por    (main_por),
            .pci_reset   (pci_reset),
            .clear_reg   (clear_bits[gi])
         );
      end
   endgenerate

   // One strobe feeds both the data bit and the pin config
   assign port8_data_clear   = clear_bits;
   assign port8_config_clear = clear_bits;

   // Open-drain: driven low when on, floating otherwise
   assign power_supply_on_n_out = 1'b0;
   assign power_supply_on_n_oe  = supply_on_reg;

   // Select register lives on the standby domain reset
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         port8_reset_select_reg <= `GPS_RST_SEL_RESET;
      end
      else if (standby_por)
      begin
         port8_reset_select_reg <= `GPS_RST_SEL_RESET;
      end
      else if (wr_access && reg_decode(paddr) == 2'd1)
      begin
         port8_reset_select_reg <= pwdata[7:0];
      end
   end

   // Supply control is battery backed: only resetn clears it
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         supply_control_reg <= `GPS_SUPPLY_CTRL_RESET;
      end
      else if (wr_access && reg_decode(paddr) == 2'd2)
      begin
         supply_control_reg <= pwdata[7:0] & `GPS_SC_MASK;
      end
   end

   // Pending wake survives the loss; override cancels it
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wake_pending_reg <= 1'b0;
      end
      else if (button_override_flag)
      begin
         wake_pending_reg <= 1'b0;
      end
      else if (wake_event)
      begin
         wake_pending_reg <= 1'b1;
      end
      else if (standby_por)
      begin
         wake_pending_reg <= 1'b0;
      end
   end

   // Supply state machine
   always @*
   begin
      state_next     = state_reg;
      supply_on_next = supply_on_reg;
      case (state_reg)
         ST_RUN:
         begin
            supply_on_next = main_on_request;
            if (!standby_present)
               state_next = ST_LOST;
         end
         ST_LOST:
         begin
            if (standby_por)
            begin
               state_next = ST_RUN;
               if (wake_pending_reg && !button_override_flag)
                  supply_on_next = 1'b1;
               else if (standby_loss_keep_off)
                  supply_on_next = 1'b0;
               else if (standby_loss_power_on)
                  supply_on_next = 1'b1;
               else
                  supply_on_next = last_on_reg;
               if (!supply_on_next)
                  state_next = ST_OFF;
            end
         end
         ST_OFF:
         begin
            // Stay off until the request drops and rises again
            supply_on_next = 1'b0;
            if (!standby_present)
               state_next = ST_LOST;
            else if (!main_on_request)
               state_next = ST_RUN;
         end
         default:
         begin
            state_next     = ST_RUN;
            supply_on_next = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg     <= ST_RUN;
         supply_on_reg <= 1'b0;
         last_on_reg   <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         supply_on_reg <= supply_on_next;
         // Remember the on state only while the rail is up
         if (state_reg != ST_LOST && standby_present)
            last_on_reg <= supply_on_reg;
      end
   end

   // APB read data and error, captured in the setup cycle
   always @*
   begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      case (reg_decode(paddr))
         2'd1: rdata_next[7:0] = port8_reset_select_reg;
         2'd2: rdata_next[7:0] = supply_control_reg;
         2'd3:
         begin
            rdata_next[`GPS_ST_STANDBY]      = standby_present;
            rdata_next[`GPS_ST_PIN_LEVEL]    = power_supply_on_n_in;
            rdata_next[`GPS_ST_SUPPLY_ON]    = supply_on_reg;
            rdata_next[`GPS_ST_WAKE_PENDING] = wake_pending_reg;
            rdata_next[`GPS_ST_LAST_ON]      = last_on_reg;
            err_next = pwrite;
         end
         default: err_next = 1'b1;
      endcase
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
         pslverr <= err_next;
      end
   end

endmodule

// File: test/gps_power_ctrl_properties.sv
`timescale 1ns/100ps
module gps_power_ctrl_properties
#(
   parameter NBITS = 8
)
(
   input wire             core_clk,
   input wire             resetn,
   input wire             psel,
   input wire             penable,
   input wire [11:0]      paddr,
   input wire [31:0]      prdata,
   input wire             pready,
   input wire             pslverr,
   input wire             standby_por,
   input wire             main_por,
   input wire             pci_reset,
   input wire [NBITS-1:0] port8_data_clear,
   input wire [NBITS-1:0] port8_config_clear,
   input wire             power_supply_on_n_out,
   input wire             power_supply_on_n_oe,
   input wire             main_on_request
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_standby_all: assert property (standby_por |=> &port8_data_clear)
      else $error("standby reset missed a bit");
   chk_clear_pair: assert property (port8_data_clear == port8_config_clear)
      else $error("data and config clears differ");
   chk_clear_quiet: assert property
      (!standby_por && !main_por && !pci_reset |=> port8_data_clear == 0)
      else $error("clear without cause");
   chk_pin_cause: assert property
      (power_supply_on_n_out == 1'b0 && (!$rose(power_supply_on_n_oe)
      || $past(main_on_request) || $past(standby_por)))
      else $error("supply pin driven without cause");
   chk_unmapped_err: assert property (psel && !penable
      && !(paddr inside {12'h3D8, 12'h3E0, 12'h3E8}) |=> pslverr && prdata == 0)
      else $error("unmapped access accepted");
   chk_upper_zero: assert property (psel && !penable |=> prdata[31:8] == 0)
      else $error("upper read bits set");
   chk_read_hold: assert property (psel && penable |=> $stable(prdata))
      else $error("read data moved");
endmodule

// File: test/gps_supply_model.sv
`timescale 1ns/100ps
module gps_supply_model
(
   input  wire power_supply_on_n_out,
   input  wire power_supply_on_n_oe,
   output wire pin_level,
   output wire main_rail_on
);
   // Board pull-up: a released pin reads high, supply stays off
   assign pin_level    = power_supply_on_n_oe ? power_supply_on_n_out : 1'b1;
   assign main_rail_on = !pin_level;
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
`include "gps_defines.vh"
module tb;
   localparam [11:0] A_SEL = {2'b00, `GPS_IDX_RST_SEL, 2'b00};
   localparam [11:0] A_CTL = {2'b00, `GPS_IDX_SUPPLY_CTRL, 2'b00};
   localparam [11:0] A_STS = {2'b00, `GPS_IDX_SUPPLY_STATUS, 2'b00};
   reg core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0;
   reg standby_por = 0, main_por = 0, pci_reset = 0, standby_present = 1;
   reg alarm_fire = 0, alarm_enable = 1, button_override_flag = 0, main_on_request = 0;
   wire [31:0] prdata;
   wire pready, pslverr, pin, main_on, ps_out, ps_oe;
   wire [7:0] port8_data_clear, port8_config_clear;
   int n_fail = 0, check_count = 0;
   always #12.5 core_clk = !core_clk;
   gps_power_ctrl #(.NBITS(8)) gps_power_ctrl_i (.core_clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .standby_por, .main_por,
      .pci_reset, .standby_present, .alarm_fire, .alarm_enable, .button_override_flag,
      .main_on_request, .port8_data_clear, .port8_config_clear,
      .power_supply_on_n_in(pin), .power_supply_on_n_out(ps_out),
      .power_supply_on_n_oe(ps_oe));
   gps_supply_model gps_supply_model_i (.power_supply_on_n_out(ps_out),
      .power_supply_on_n_oe(ps_oe), .pin_level(pin), .main_rail_on(main_on));
   task check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic er);
      @(posedge core_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      if (!w) check(prdata, e);
      check({31'h0, pslverr}, {31'h0, er});
      psel <= 0;
      penable <= 0;
   endtask
   task t_regs;
      apb(0, A_STS, 0, 32'h3, 0);
      apb(0, A_SEL, 0, 32'h0, 0);
      apb(0, A_CTL, 0, 32'h0, 0);
      apb(1, A_CTL, 32'hFFFF_FFF9, 0, 0);
      apb(0, A_CTL, 0, 32'h1, 0);
      apb(0, 12'h100, 0, 32'h0, 1);
      apb(1, 12'h100, 32'hFF, 0, 1);
      apb(1, A_STS, 32'hFF, 0, 1);
   endtask
   task rst_pulse(input int k, input logic [7:0] e);
      @(posedge core_clk);
      case (k)
         0: pci_reset <= 1;
         1: main_por <= 1;
         default: standby_por <= 1;
      endcase
      @(posedge core_clk);
      {pci_reset, main_por, standby_por} <= 3'h0;
      #1 check({24'h0, port8_data_clear}, {24'h0, e});
      check({24'h0, port8_config_clear}, {24'h0, e});
   endtask
   task t_sel(input logic [7:0] s);
      apb(1, A_SEL, {24'h0, s}, 0, 0);
      rst_pulse(0, s);
      rst_pulse(1, s);
      rst_pulse(2, 8'hFF);
      apb(0, A_SEL, 0, 32'h0, 0);
   endtask
   task t_loss(input logic [7:0] c, input logic req, al, ov, ex);
      apb(1, A_CTL, {24'h0, c}, 0, 0);
      main_on_request <= req;
      button_override_flag <= ov;
      repeat (3) @(posedge core_clk);
      standby_present <= 0;
      repeat (2) @(posedge core_clk);
      alarm_fire <= al;
      @(posedge core_clk);
      alarm_fire <= 0;
      apb(0, A_STS, 0, {27'h0, req, al & !ov & c[0], req, !req, 1'b0}, 0);
      standby_present <= 1;
      standby_por <= 1;
      @(posedge core_clk);
      standby_por <= 0;
      #1 check({31'h0, ps_oe}, {31'h0, ex});
      check({31'h0, main_on}, {31'h0, ex});
      @(posedge core_clk);
      main_on_request <= 0;
      button_override_flag <= 0;
      repeat (3) @(posedge core_clk);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk);
      resetn <= 1;
      t_regs;
      t_sel(8'hA5);
      t_sel(8'h5A);
      t_sel(8'h00);
      t_loss(8'h01, 0, 1, 0, 1);
      t_loss(8'h01, 0, 1, 1, 0);
      t_loss(8'h02, 1, 0, 0, 0);
      t_loss(8'h00, 1, 0, 0, 1);
      t_loss(8'h00, 0, 0, 0, 0);
      t_loss(8'h04, 0, 0, 0, 1);
      test_done;
   end
   initial
   begin
      #100000;
      n_fail++;
      test_done;
   end
endmodule
bind gps_power_ctrl gps_power_ctrl_properties #(.NBITS(NBITS)) chk_i (.core_clk, .resetn,
   .psel, .penable, .paddr, .prdata, .pready, .pslverr, .standby_por, .main_por,
   .pci_reset, .port8_data_clear, .port8_config_clear, .power_supply_on_n_out,
   .power_supply_on_n_oe, .main_on_request);
